// ===== rtl/pin_ctrl_defines.vh
// constants for the power and probe pin control block
// assumes a 20 MHz sys_clk; included by bare name
`ifndef PIN_CTRL_DEFINES_VH
`define PIN_CTRL_DEFINES_VH
`define CLK_PERIOD_NS 50
`define LP_ENTRY_NS 800
`define LP_EXIT_US 200
`define LP_ENTRY_CYC ((`LP_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LP_EXIT_CYC ((`LP_EXIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16
`define ZERO_CNT 16'h0000
`define ONE_CNT 16'h0001
`endif

// ===== rtl/pin_cell.v
// one multifunction pad cell: user path or diagnostic path, with gating
// assumes all inputs synchronous to sys_clk
`timescale 1ns/1ps
module pin_cell (
    input wire sys_clk,
    input wire rst,
    input wire diag_sel,
    input wire diag_out,
    input wire diag_oe,
    input wire user_out,
    input wire user_oe,
    input wire pad_in,
    input wire pads_off,
    input wire inbuf_on,
    output reg pad_out,
    output reg pad_oe,
    output reg core_in
);
    always @(posedge sys_clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            core_in <= 1'b0;
        end else begin
            pad_out <= pads_off ? 1'b0 : (diag_sel ? diag_out : user_out);
            pad_oe <= pads_off ? 1'b0 : (diag_sel ? diag_oe : user_oe);
            core_in <= (inbuf_on && !diag_sel) ? pad_in : 1'b0;
        end
    end
endmodule

// ===== rtl/power_and_probe_pin_control.v
// power mode sequencing and multifunction pin steering
// assumes synchronous pins; probe disable fuse input is sticky once seen
`timescale 1ns/1ps
`include "pin_ctrl_defines.vh"
module power_and_probe_pin_control #(
    parameter ENTRY_CYC = `LP_ENTRY_CYC,
    parameter EXIT_CYC = `LP_EXIT_CYC,
    parameter UNUSED_TRISTATE = 0
) (
    input wire sys_clk,
    input wire rst,
    input wire low_power_request,
    input wire mode,
    input wire probe_disable_fuse,
    input wire checksum_active,
    input wire probe_node_a,
    input wire probe_node_b,
    input wire diag_tx_data,
    input wire diag_tx_en,
    input wire quadrant_clock_used,
    input wire no_connect_in,
    input wire unused_pad_in,
    input wire probe_a_pad_in,
    input wire probe_b_pad_in,
    input wire diag_serial_in,
    input wire diag_serial_out_pad_in,
    input wire quadrant_clock_in,
    input wire [3:0] user_out,
    input wire [3:0] user_oe,
    input wire user_qclk_out,
    input wire user_qclk_oe,
    output reg probe_out_a,
    output reg probe_out_a_oe,
    output reg probe_out_b,
    output reg probe_out_b_oe,
    output reg diag_serial_out,
    output reg diag_serial_out_oe,
    output reg diag_serial_in_out,
    output reg diag_serial_in_oe,
    output reg qclk_pad_out,
    output reg qclk_pad_oe,
    output reg unused_pad_out,
    output reg unused_pad_oe,
    output reg [3:0] core_pad_in,
    output reg core_qclk,
    output reg core_qclk_in,
    output reg diag_rx_data,
    output reg diag_rx_valid,
    output reg core_enable,
    output reg inbuf_enable,
    output reg low_power_state
);
    localparam ST_RUN = 4'b0001;
    localparam ST_ENTER = 4'b0010;
    localparam ST_LOW = 4'b0100;
    localparam ST_WAKE = 4'b1000;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [`CNT_W-1:0] cnt_ff;
    reg [`CNT_W-1:0] nxt_cnt;
    reg probe_lock_ff;
    wire pads_off;
    wire diag_mode;
    wire probe_sel;
    wire sdo_sel;
    wire [3:0] cell_out;
    wire [3:0] cell_oe;
    wire [3:0] cell_in;
    wire [3:0] diag_out_v;
    wire [3:0] diag_oe_v;
    wire [3:0] diag_sel_v;
    wire [3:0] pad_in_v;

    function [`CNT_W-1:0] dec_sat;
        input [`CNT_W-1:0] v;
        begin
            dec_sat = (v == `ZERO_CNT) ? `ZERO_CNT : v - `ONE_CNT;
        end
    endfunction

    function [`CNT_W-1:0] cyc_load;
        input [31:0] cyc;
        begin
            cyc_load = cyc[`CNT_W-1:0] - `ONE_CNT;
        end
    endfunction

    function lp_off;
        input [3:0] st;
        begin
            lp_off = (st == ST_LOW) || (st == ST_WAKE);
        end
    endfunction

    // power sequencer: run, entry delay, low power, recovery
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = dec_sat(cnt_ff);
        case (state_ff)
            ST_RUN: begin
                if (low_power_request) begin
                    nxt_state = ST_ENTER;
                    nxt_cnt = cyc_load(ENTRY_CYC);
                end
            end
            ST_ENTER: begin
                if (!low_power_request) begin
                    nxt_state = ST_RUN;
                end else if (cnt_ff == `ZERO_CNT) begin
                    nxt_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (!low_power_request) begin
                    nxt_state = ST_WAKE;
                    nxt_cnt = cyc_load(EXIT_CYC);
                end
            end
            ST_WAKE: begin
                if (low_power_request) begin
                    nxt_state = ST_ENTER;
                    nxt_cnt = cyc_load(ENTRY_CYC);
                end else if (cnt_ff == `ZERO_CNT) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
                nxt_cnt = `ZERO_CNT;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_RUN;
            cnt_ff <= `ZERO_CNT;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // probe disable is sticky until reset
    always @(posedge sys_clk) begin
        if (rst) begin
            probe_lock_ff <= 1'b0;
        end else if (probe_disable_fuse) begin
            probe_lock_ff <= 1'b1;
        end
    end

    assign pads_off = lp_off(nxt_state);
    assign diag_mode = mode && !pads_off;
    assign probe_sel = mode && !probe_lock_ff && !probe_disable_fuse;
    assign sdo_sel = mode || checksum_active;

    // cells: 0 probe a, 1 probe b, 2 serial out, 3 serial in
    assign diag_sel_v = {mode, sdo_sel, probe_sel, probe_sel};
    assign diag_out_v = {1'b0, diag_tx_data, probe_node_b, probe_node_a};
    assign diag_oe_v = {1'b0, diag_tx_en | checksum_active, 1'b1, 1'b1};
    assign pad_in_v = {diag_serial_in, diag_serial_out_pad_in, probe_b_pad_in, probe_a_pad_in};

    // probe a pad
    pin_cell u_probe_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .diag_sel(diag_sel_v[0]),
        .diag_out(diag_out_v[0]),
        .diag_oe(diag_oe_v[0]),
        .user_out(user_out[0]),
        .user_oe(user_oe[0]),
        .pad_in(pad_in_v[0]),
        .pads_off(pads_off),
        .inbuf_on(!pads_off),
        .pad_out(cell_out[0]),
        .pad_oe(cell_oe[0]),
        .core_in(cell_in[0])
    );

    // probe b pad
    pin_cell u_probe_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .diag_sel(diag_sel_v[1]),
        .diag_out(diag_out_v[1]),
        .diag_oe(diag_oe_v[1]),
        .user_out(user_out[1]),
        .user_oe(user_oe[1]),
        .pad_in(pad_in_v[1]),
        .pads_off(pads_off),
        .inbuf_on(!pads_off),
        .pad_out(cell_out[1]),
        .pad_oe(cell_oe[1]),
        .core_in(cell_in[1])
    );

    // serial output pad
    pin_cell u_sdo (
        .sys_clk(sys_clk),
        .rst(rst),
        .diag_sel(diag_sel_v[2]),
        .diag_out(diag_out_v[2]),
        .diag_oe(diag_oe_v[2]),
        .user_out(user_out[2]),
        .user_oe(user_oe[2]),
        .pad_in(pad_in_v[2]),
        .pads_off(pads_off),
        .inbuf_on(!pads_off),
        .pad_out(cell_out[2]),
        .pad_oe(cell_oe[2]),
        .core_in(cell_in[2])
    );

    // serial input pad
    pin_cell u_sdi (
        .sys_clk(sys_clk),
        .rst(rst),
        .diag_sel(diag_sel_v[3]),
        .diag_out(diag_out_v[3]),
        .diag_oe(diag_oe_v[3]),
        .user_out(user_out[3]),
        .user_oe(user_oe[3]),
        .pad_in(pad_in_v[3]),
        .pads_off(pads_off),
        .inbuf_on(!pads_off),
        .pad_out(cell_out[3]),
        .pad_oe(cell_oe[3]),
        .core_in(cell_in[3])
    );

    // top outputs taken straight from the pad cell flip-flops
    always @* begin
        probe_out_a = cell_out[0];
        probe_out_a_oe = cell_oe[0];
        probe_out_b = cell_out[1];
        probe_out_b_oe = cell_oe[1];
        diag_serial_out = cell_out[2];
        diag_serial_out_oe = cell_oe[2];
        diag_serial_in_out = cell_out[3];
        diag_serial_in_oe = cell_oe[3];
        core_pad_in = cell_in;
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            qclk_pad_out <= 1'b0;
            qclk_pad_oe <= 1'b0;
            unused_pad_out <= 1'b0;
            unused_pad_oe <= 1'b0;
            core_qclk <= 1'b0;
            core_qclk_in <= 1'b0;
        end else begin
            // quadrant clock: clock net when used, else user pin
            qclk_pad_out <= (!pads_off && !quadrant_clock_used) ? user_qclk_out : 1'b0;
            qclk_pad_oe <= !pads_off && !quadrant_clock_used && user_qclk_oe;
            core_qclk <= (!pads_off && quadrant_clock_used) ? quadrant_clock_in : 1'b0;
            core_qclk_in <= (!pads_off && !quadrant_clock_used) ? quadrant_clock_in : 1'b0;
            // unused pins: driven low, or left floating on large parts
            unused_pad_out <= 1'b0;
            unused_pad_oe <= (UNUSED_TRISTATE == 0) && !pads_off;
        end
    end

    // serial input feeds the diagnostic path only in mode
    always @(posedge sys_clk) begin
        if (rst) begin
            diag_rx_data <= 1'b0;
            diag_rx_valid <= 1'b0;
        end else begin
            diag_rx_data <= diag_mode ? diag_serial_in : 1'b0;
            diag_rx_valid <= diag_mode;
        end
    end

    // power flags follow the next state; core_enable and inbuf_enable switch with the pads
    always @(posedge sys_clk) begin
        if (rst) begin
            core_enable <= 1'b1;
            inbuf_enable <= 1'b1;
            low_power_state <= 1'b0;
        end else begin
            core_enable <= !lp_off(nxt_state);
            inbuf_enable <= !lp_off(nxt_state);
            low_power_state <= (nxt_state == ST_LOW);
        end
    end
    // no_connect_in and unused_pad_in are deliberately never read
endmodule

// ===== tb/board_model.sv
// board side of the five multifunction pads
// assumes bit order probe a, probe b, serial out, serial in, quadrant clock
`timescale 1ns/1ps
module board_model (
    input wire logic [4:0] pad_out,
    input wire logic [4:0] pad_oe,
    input wire logic [4:0] board_val,
    output logic [4:0] pad_in
);
    // board drives a pad only where the device has let go of it
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_val);
endmodule

// ===== tb/pin_ctrl_properties.sv
// checker for power_and_probe_pin_control
// assumes it is bound onto the top module, single clock
`timescale 1ns/1ps
module pin_ctrl_properties #(parameter ENTRY_CYC = 16, parameter EXIT_CYC = 4000) (
    input logic sys_clk, rst, low_power_request, mode, probe_disable_fuse, checksum_active,
    input logic probe_node_a, probe_node_b, diag_tx_data, diag_tx_en,
    input logic [3:0] user_out, user_oe,
    input logic probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe,
    input logic diag_serial_out, diag_serial_out_oe, diag_serial_in_oe, qclk_pad_oe,
    input logic core_enable, inbuf_enable, low_power_state
);
    reg [15:0] hi_ff = 0, lo_ff = 0;
    reg lock_ff = 0;
    reg [1:0] run_ff = 0;
    wire run = core_enable && &run_ff;
    wire pads = probe_out_a_oe | probe_out_b_oe | diag_serial_out_oe | diag_serial_in_oe | qclk_pad_oe;
    always @(posedge sys_clk) begin
        hi_ff <= (low_power_request && !rst) ? hi_ff + 16'h0001 : 16'h0000;
        lo_ff <= low_power_request ? 16'h0000 : lo_ff + 16'h0001;
        lock_ff <= !rst && (lock_ff || probe_disable_fuse);
        run_ff <= {run_ff[0], core_enable && !rst};
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence probe_on; $past(mode) && !lock_ff; endsequence
    sequence sdo_diag; $past(mode) || $past(checksum_active); endsequence
    entry_delay_a: assert property ($rose(low_power_state) |-> hi_ff >= ENTRY_CYC + 1 && hi_ff <= ENTRY_CYC + 2)
        else $error("entry time wrong");
    exit_delay_a: assert property ($rose(core_enable) |-> lo_ff >= EXIT_CYC && lo_ff <= EXIT_CYC + 3)
        else $error("resume time wrong");
    lp_shutdown_a: assert property (low_power_state |-> !core_enable && !inbuf_enable && !pads)
        else $error("not shut down");
    wake_tristate_a: assert property (!core_enable |-> !pads)
        else $error("pad driven while off");
    probe_steer_a: assert property (run ##0 probe_on |-> probe_out_a == $past(probe_node_a) && probe_out_a_oe)
        else $error("probe a wrong");
    probe_pair_a: assert property (run ##0 probe_on |-> probe_out_b == $past(probe_node_b) && probe_out_b_oe)
        else $error("probe b wrong");
    probe_lock_a: assert property (run && lock_ff |-> probe_out_a == $past(user_out[0]) && probe_out_b_oe == $past(user_oe[1]))
        else $error("probe shown after lock");
    sdo_diag_a: assert property (run ##0 sdo_diag |-> diag_serial_out == $past(diag_tx_data) &&
        diag_serial_out_oe == ($past(checksum_active) || $past(diag_tx_en)))
        else $error("serial out diag wrong");
    sdo_user_a: assert property (run && !$past(mode) && !$past(checksum_active) |->
        diag_serial_out == $past(user_out[2]) && diag_serial_out_oe == $past(user_oe[2]))
        else $error("serial out user wrong");
endmodule
bind power_and_probe_pin_control pin_ctrl_properties #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) props (
    .sys_clk, .rst, .low_power_request, .mode, .probe_disable_fuse, .checksum_active, .probe_node_a,
    .probe_node_b, .diag_tx_data, .diag_tx_en, .user_out, .user_oe, .probe_out_a, .probe_out_a_oe,
    .probe_out_b, .probe_out_b_oe, .diag_serial_out, .diag_serial_out_oe, .diag_serial_in_oe,
    .qclk_pad_oe, .core_enable, .inbuf_enable, .low_power_state);

// ===== tb/tb_power_and_probe_pin_control.sv
// self-checking bench for power_and_probe_pin_control
// assumes board_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin miscompares++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_power_and_probe_pin_control;
    localparam int EN = 2;
    localparam int EX = 5;
    reg sys_clk = 0, rst = 1, lp = 0, mode = 0, fuse = 0, cks = 0, qu = 0;
    reg [3:0] uo = 0, ue = 0, pu, pue;
    reg [4:0] bv = 0, ppi;
    reg [7:0] r = 0, pr;
    reg [31:0] s;
    reg pm, pc, pq, lk;
    wire [4:0] po, pe, pi;
    wire [3:0] cpi;
    wire ce, ie, lps, uno, unoe, rxd, rxv, cq, cqi;
    wire pd = pm && !lk;
    int miscompares = 0, n_checks = 0, n = 0, st = 0;
    always #25 sys_clk = ~sys_clk;
    power_and_probe_pin_control #(.ENTRY_CYC(EN), .EXIT_CYC(EX)) dut (
        .sys_clk(sys_clk), .rst(rst), .low_power_request(lp), .mode(mode), .probe_disable_fuse(fuse),
        .checksum_active(cks), .probe_node_a(r[0]), .probe_node_b(r[1]), .diag_tx_data(r[2]),
        .diag_tx_en(r[3]), .quadrant_clock_used(qu), .no_connect_in(r[4]), .unused_pad_in(r[5]),
        .probe_a_pad_in(pi[0]), .probe_b_pad_in(pi[1]), .diag_serial_in(pi[3]),
        .diag_serial_out_pad_in(pi[2]), .quadrant_clock_in(pi[4]), .user_out(uo), .user_oe(ue),
        .user_qclk_out(r[6]), .user_qclk_oe(r[7]), .probe_out_a(po[0]), .probe_out_a_oe(pe[0]),
        .probe_out_b(po[1]), .probe_out_b_oe(pe[1]), .diag_serial_out(po[2]), .diag_serial_out_oe(pe[2]),
        .diag_serial_in_out(po[3]), .diag_serial_in_oe(pe[3]), .qclk_pad_out(po[4]), .qclk_pad_oe(pe[4]),
        .unused_pad_out(uno), .unused_pad_oe(unoe), .core_pad_in(cpi), .core_qclk(cq), .core_qclk_in(cqi),
        .diag_rx_data(rxd), .diag_rx_valid(rxv), .core_enable(ce), .inbuf_enable(ie), .low_power_state(lps));
    board_model board (.pad_out(po), .pad_oe(pe), .board_val(bv), .pad_in(pi));
    always @(posedge sys_clk) begin
        pm <= mode; pc <= cks; pq <= qu; pu <= uo; pue <= ue; pr <= r; ppi <= pi;
        lk <= !rst && (lk || fuse);
    end
    task automatic rnd(input int k);
        repeat (k) begin
            @(negedge sys_clk);
            st = ce ? st + 1 : 0;
            if (st > 3) begin
                `CK("probe", {pd ? pr[1:0] : pu[1:0], pd ? 2'b11 : pue[1:0]}, {po[1:0], pe[1:0]})
                `CK("sdo", {pc | pm ? pr[2] : pu[2], pc ? 1'b1 : pm ? pr[3] : pue[2]}, {po[2], pe[2]})
                `CK("sdi", pm ? {1'b0, ppi[3], 1'b0} : {pue[3], pu[3], ppi[3]}, {pe[3], pm ? rxd : po[3], cpi[3]})
                `CK("rx_valid", pm, rxv)
                `CK("core_in", {(pm | pc) ? 1'b0 : ppi[2], pd ? 2'b00 : ppi[1:0]}, cpi[2:0])
                if (!pq) `CK("qclk", pr[7:6], {pe[4], po[4]})
                else `CK("qclk_off", 2'b00, {pe[4], po[4]})
                `CK("qclk_core", pq ? {ppi[4], 1'b0} : {1'b0, ppi[4]}, {cq, cqi})
                `CK("unused", 2'b01, {uno, unoe})
            end
            s = $urandom; r = s[7:0]; uo = s[11:8]; ue = s[15:12]; bv = s[20:16];
            mode = s[21] | s[22]; cks = s[23] & s[24] & s[25]; qu = s[26];
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #(2000 * 50);
        miscompares++;
        test_done;
    end
    initial begin
        void'($urandom(32'hB4AE8EAC));
        repeat (10) @(negedge sys_clk);
        rst = 0;
        rnd(200);
        lp = 1;
        repeat (EN) @(negedge sys_clk);
        lp = 0;
        repeat (EN + 3) begin @(negedge sys_clk); `CK("abort", 1'b0, lps) end
        lp = 1;
        while (!lps && n < 50) begin @(negedge sys_clk); n++; end
        `CK("entry", EN + 1, n)
        `CK("off", 7'h00, {pe, ce, ie})
        lp = 0;
        n = 0;
        while (!ce && n < 50) begin @(negedge sys_clk); n++; if (!ce) `CK("wake", 5'h00, pe) end
        `CK("exit", EX + 1, n)
        rnd(200);
        fuse = 1;
        rnd(1);
        fuse = 0;
        rnd(200);
        test_done;
    end
endmodule
